// >>> design/drive_supervisor.v
/*
  Supervisory control of one networked positioning drive: limit scaling,
  cyclic-over-acyclic priority, blockage fault with history, edge-based
  acknowledge, readjustment and master-timeout abort.
  Assumes all inputs come from logic on MCLK; cyclic and acyclic update
  strobes are one-cycle pulses.
*/
`timescale 1ns/1ps
`include "drive_supervisor_regs.vh"

// Operation
// - Speed scaled by param 166, torque by nominal
// - Cyclic data overrides acyclic writes
// - Blockage aborts run, enters Fault
// - Blockage fault logged into history 108..115
// - Bit 7 falling edge: Fault to inhibit
// - Bit 0 falling edge leaves inhibit
// - Power-up readjust only when within 5 degrees
// - Correct position when pushed outside tolerance
// - Steps = 256 * numerator / denominator
// - Factors reset to 256 and 1
// - Communication timeout aborts all positioning
module drive_supervisor #(
  parameter [31:0] TIMEOUT_CYCLES =
    `COMM_TIMEOUT_MS * 1000000 / `CLK_PERIOD_NS
) (
  input  wire        MCLK,
  input  wire        RESET,
  input  wire        CYC_VALID,
  input  wire        CYC_STROBE,
  input  wire [15:0] CYC_CONTROL,
  input  wire [7:0]  CYC_SPEED_PCT,
  input  wire [7:0]  CYC_TORQUE_PCT,
  input  wire [31:0] CYC_TARGET,
  input  wire        ACY_WRITE,
  input  wire [8:0]  ACY_PNU,
  input  wire [31:0] ACY_VALUE,
  input  wire        COMM_ALIVE,
  input  wire        BLOCKED,
  input  wire        START,
  input  wire [31:0] ACTUAL_POS,
  input  wire [31:0] SAVED_TARGET,
  input  wire [31:0] TOLERANCE,
  input  wire        IN_POSITION,
  input  wire [15:0] NOMINAL_TORQUE,
  input  wire [2:0]  FAULT_RD_INDEX,
  output reg  [2:0]  STATE,
  output reg         RUN_ABORT,
  output reg         READJUST,
  output reg  [31:0] SPEED_LIMIT,
  output reg  [31:0] TORQUE_LIMIT,
  output reg  [31:0] POS_TARGET,
  output reg  [31:0] STEPS_PER_REV,
  output reg  [15:0] CONTROL_WORD,
  output reg         COMM_TIMEOUT,
  output reg  [15:0] FAULT_ENTRY,
  output reg  [3:0]  FAULT_COUNT
);

  // Parameter storage
  reg [15:0] speed_ref_q;     // Max speed, 100% reference
  reg [7:0]  speed_pct_q;     // Active speed percentage
  reg [7:0]  torque_pct_q;    // Active torque percentage
  reg [15:0] numer_q;         // Numerator factor
  reg [15:0] denom_q;         // Denominator factor
  reg [15:0] fault_mem [0:`FAULT_DEPTH-1];  // Fault history
  reg [2:0]  fault_wr_q;      // Next history slot
  reg [31:0] tmo_cnt_q;       // Cycles since last traffic
  reg        powerup_q;       // First-cycle check pending
  reg        settled_q;       // Target reached or stopped
  reg [2:0]  state_d;         // Next state
  wire       ack_fall;        // Fault acknowledge edge
  wire       on_fall;         // Switch-on bit falling edge
  wire [31:0] pos_diff;       // Absolute position error
  wire       tmo_hit;         // Timeout reached
  integer    i;

  localparam [31:0] READJ_INCR = `READJ_LIMIT_DEG * `INCR_PER_REV / 360;

  // Edge detectors on the active control word
  falling_edge_detect u_ack_edge (
    .MCLK       (MCLK),
    .RESET      (RESET),
    .level_in   (CONTROL_WORD[`CW_FAULT_ACK_BIT]),
    .fall_pulse (ack_fall)
  );
  falling_edge_detect u_on_edge (
    .MCLK       (MCLK),
    .RESET      (RESET),
    .level_in   (CONTROL_WORD[`CW_SWITCH_ON_BIT]),
    .fall_pulse (on_fall)
  );

  assign pos_diff = (ACTUAL_POS > POS_TARGET) ? ACTUAL_POS - POS_TARGET
                                              : POS_TARGET - ACTUAL_POS;
  assign tmo_hit  = (tmo_cnt_q >= TIMEOUT_CYCLES);

  // Process data: cyclic wins over acyclic while connected
  always @(posedge MCLK) begin
    if (RESET) begin
      CONTROL_WORD <= 16'h0000;
      speed_pct_q  <= 8'h00;
      torque_pct_q <= 8'h00;
      POS_TARGET   <= 32'h0000_0000;
      speed_ref_q  <= 16'h0000;
      numer_q      <= `NUMERATOR_RESET;
      denom_q      <= `DENOMINATOR_RESET;
    end else begin
      if (ACY_WRITE) begin
        // Configuration parameters always writable
        if (ACY_PNU == `PNU_SPEED_REF) begin
          speed_ref_q <= ACY_VALUE[15:0];
        end else if (ACY_PNU == `PNU_NUMERATOR) begin
          numer_q <= ACY_VALUE[15:0];
        end else if (ACY_PNU == `PNU_DENOMINATOR) begin
          // Zero denominator refused
          if (ACY_VALUE[15:0] != 16'h0000) begin
            denom_q <= ACY_VALUE[15:0];
          end
        end else if (!CYC_VALID) begin
          // Process values only when no cyclic link
          if (ACY_PNU == `PNU_SPEED_MAX) begin
            speed_pct_q <= ACY_VALUE[7:0];
          end else if (ACY_PNU == `PNU_TORQUE_MAX) begin
            torque_pct_q <= ACY_VALUE[7:0];
          end
        end
      end
      if (CYC_VALID && CYC_STROBE) begin
        // Cyclic values overwrite
        CONTROL_WORD <= CYC_CONTROL;
        speed_pct_q  <= CYC_SPEED_PCT;
        torque_pct_q <= CYC_TORQUE_PCT;
        POS_TARGET   <= CYC_TARGET;
      end else if (powerup_q) begin
        // Restore saved target at power-up
        POS_TARGET <= SAVED_TARGET;
      end
    end
  end

  // Limits and resolution
  always @(posedge MCLK) begin
    if (RESET) begin
      SPEED_LIMIT   <= 32'h0000_0000;
      TORQUE_LIMIT  <= 32'h0000_0000;
      STEPS_PER_REV <= 32'h0001_0000;
    end else begin
      SPEED_LIMIT   <= (speed_ref_q * speed_pct_q) / 32'd100;
      TORQUE_LIMIT  <= (NOMINAL_TORQUE * torque_pct_q) / 32'd100;
      STEPS_PER_REV <= ({16'h0000, `STEPS_BASE} * numer_q) / denom_q;
    end
  end

  // Master traffic watchdog
  always @(posedge MCLK) begin
    if (RESET) begin
      tmo_cnt_q    <= 32'h0000_0000;
      COMM_TIMEOUT <= 1'b0;
    end else if (COMM_ALIVE) begin
      tmo_cnt_q    <= 32'h0000_0000;
      COMM_TIMEOUT <= 1'b0;
    end else if (tmo_hit) begin
      COMM_TIMEOUT <= 1'b1;
    end else begin
      tmo_cnt_q <= tmo_cnt_q + 32'd1;
    end
  end

  // Next-state logic
  always @* begin
    state_d = STATE;
    case (STATE)
      `ST_NOT_READY: begin
        state_d = `ST_INHIBIT;
      end
      `ST_INHIBIT: begin
        if (on_fall) begin
          state_d = `ST_READY;
        end
      end
      `ST_READY: begin
        // Runs need nonzero speed and torque percentages
        if (START && speed_pct_q != 8'h00 && torque_pct_q != 8'h00) begin
          state_d = `ST_RUN;
        end
      end
      `ST_RUN: begin
        if (BLOCKED) begin
          state_d = `ST_FAULT;
        end else if (tmo_hit || IN_POSITION) begin
          state_d = `ST_READY;
        end
      end
      `ST_FAULT: begin
        if (ack_fall) begin
          state_d = `ST_INHIBIT;
        end
      end
      default: begin
        state_d = `ST_NOT_READY;
      end
    endcase
  end

  // State, abort and fault history
  always @(posedge MCLK) begin
    if (RESET) begin
      STATE       <= `ST_NOT_READY;
      RUN_ABORT   <= 1'b0;
      fault_wr_q  <= 3'h0;
      FAULT_COUNT <= 4'h0;
      for (i = 0; i < `FAULT_DEPTH; i = i + 1) begin
        fault_mem[i] <= 16'h0000;
      end
    end else begin
      STATE     <= state_d;
      // Abort pulse on block or timeout during run
      RUN_ABORT <= (STATE == `ST_RUN) && (BLOCKED || tmo_hit);
      if (STATE == `ST_RUN && BLOCKED) begin
        fault_mem[fault_wr_q] <= `FAULT_CODE_BLOCK;
        fault_wr_q <= fault_wr_q + 3'h1;
        if (FAULT_COUNT != 4'h8) begin
          FAULT_COUNT <= FAULT_COUNT + 4'h1;
        end
      end
    end
  end

  // Fault history readout, newest at index 0
  always @(posedge MCLK) begin
    if (RESET) begin
      FAULT_ENTRY <= 16'h0000;
    end else begin
      FAULT_ENTRY <= fault_mem[fault_wr_q - 3'h1 - FAULT_RD_INDEX];
    end
  end

  // Readjustment: power-up window and post-settle hold
  always @(posedge MCLK) begin
    if (RESET) begin
      powerup_q <= 1'b1;
      settled_q <= 1'b0;
      READJUST  <= 1'b0;
    end else begin
      powerup_q <= 1'b0;
      if (powerup_q) begin
        // 910 increments is still under 5 degrees, so the bound is inclusive
        READJUST <= (ACTUAL_POS > SAVED_TARGET ? ACTUAL_POS - SAVED_TARGET
                     : SAVED_TARGET - ACTUAL_POS) <= READJ_INCR;
      end else if (STATE == `ST_RUN) begin
        settled_q <= 1'b0;
        READJUST  <= 1'b0;
      end else if (STATE == `ST_FAULT || COMM_TIMEOUT) begin
        READJUST  <= 1'b0;
      end else begin
        if (IN_POSITION || STATE == `ST_READY) begin
          settled_q <= 1'b1;
        end
        // Correct when pushed outside tolerance
        if (settled_q && pos_diff > TOLERANCE) begin
          READJUST <= 1'b1;
        end else if (pos_diff <= TOLERANCE && !powerup_q) begin
          READJUST <= READJUST & (pos_diff != 32'h0000_0000);
        end
      end
    end
  end

endmodule

// >>> design/drive_supervisor_regs.vh
/*
  Constants for the drive supervisor: parameter numbers, control word
  bit positions, reset values, state codes and timing counts.
  Assumes inclusion by bare name from the design files.
*/
`ifndef DRIVE_SUPERVISOR_REGS_VH
`define DRIVE_SUPERVISOR_REGS_VH

// Parameter numbers of the drive's parameter space
`define PNU_SPEED_MAX      9'd102
`define PNU_TORQUE_MAX     9'd103
`define PNU_FAULT_FIRST    9'd108
`define PNU_FAULT_LAST     9'd115
`define PNU_NUMERATOR      9'd154
`define PNU_DENOMINATOR    9'd156
`define PNU_SPEED_REF      9'd166

// Control word bit positions
`define CW_SWITCH_ON_BIT   0
`define CW_FAULT_ACK_BIT   7

// Resolution factors after reset
`define NUMERATOR_RESET    16'h0100
`define DENOMINATOR_RESET  16'h0001
`define STEPS_BASE         16'h0100

// Fault history depth (parameters 108..115)
`define FAULT_DEPTH        8
`define FAULT_CODE_BLOCK   16'h0001

// Readjustment window after power-up, degrees
`define READJ_LIMIT_DEG    5
// One revolution in position increments at 16 bit fraction
`define INCR_PER_REV       65536

// State codes
`define ST_NOT_READY       3'h0
`define ST_INHIBIT         3'h1
`define ST_READY           3'h2
`define ST_RUN             3'h3
`define ST_FAULT           3'h4

// Communication timeout, milliseconds, and clock period in ns
`define COMM_TIMEOUT_MS    100
`define CLK_PERIOD_NS      5

`endif

// >>> design/falling_edge_detect.v
/*
  Falling edge detector for one control word bit.
  Assumes the input is already in the MCLK domain.
*/
`timescale 1ns/1ps
module falling_edge_detect (
  input  wire MCLK,
  input  wire RESET,
  input  wire level_in,
  output wire fall_pulse
);
  reg prev_q;  // Value one cycle ago

  // Remember previous level; start low like the cleared control word, so no false edge
  always @(posedge MCLK) begin
    if (RESET) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= level_in;
    end
  end

  // One-cycle pulse on high-to-low transition
  assign fall_pulse = prev_q & ~level_in;
endmodule

// >>> sim/drive_supervisor_bench.sv
/*
  Self-checking bench for the drive supervisor with a scanner model.
  Assumes a 200 MHz MCLK and a shortened master timeout.
*/
`timescale 1ns/1ps
`include "drive_supervisor_regs.vh"
module drive_supervisor_bench;
  localparam [31:0] TO = 32'd50;  // Short timeout for simulation
  reg MCLK = 1'b0, RESET = 1'b1, BLOCKED = 1'b0, START = 1'b0;
  reg [15:0] nom = 16'h0;
  reg [31:0] apos = 32'h0, saved = 32'h0;  // Shaft position and stored target
  wire cv, cs, aw, al, abort, readj, tmo;
  wire [15:0] cc, cw, fe;
  wire [7:0] sp, tq;
  wire [31:0] ct, av, sl, tl, pt, spr;
  wire [8:0] pnu;
  wire [2:0] STATE;
  wire [3:0] fc;
  integer bad_count = 0, n_compared = 0, i, n, d, k;
  always #2.5 MCLK = ~MCLK;
  scanner_model scanner_model_i (.MCLK(MCLK), .CYC_VALID(cv), .CYC_STROBE(cs),
    .CYC_CONTROL(cc), .CYC_SPEED_PCT(sp), .CYC_TORQUE_PCT(tq), .CYC_TARGET(ct),
    .ACY_WRITE(aw), .ACY_PNU(pnu), .ACY_VALUE(av), .COMM_ALIVE(al));
  drive_supervisor #(.TIMEOUT_CYCLES(TO)) drive_supervisor_i (.MCLK(MCLK),
    .RESET(RESET), .CYC_VALID(cv), .CYC_STROBE(cs), .CYC_CONTROL(cc),
    .CYC_SPEED_PCT(sp), .CYC_TORQUE_PCT(tq), .CYC_TARGET(ct), .ACY_WRITE(aw),
    .ACY_PNU(pnu), .ACY_VALUE(av), .COMM_ALIVE(al), .BLOCKED(BLOCKED),
    .START(START), .ACTUAL_POS(apos), .SAVED_TARGET(saved), .TOLERANCE(32'h10),
    .IN_POSITION(1'b0), .NOMINAL_TORQUE(nom), .FAULT_RD_INDEX(3'h0),
    .STATE(STATE), .RUN_ABORT(abort), .READJUST(readj), .SPEED_LIMIT(sl),
    .TORQUE_LIMIT(tl), .POS_TARGET(pt), .STEPS_PER_REV(spr), .CONTROL_WORD(cw),
    .COMM_TIMEOUT(tmo), .FAULT_ENTRY(fe), .FAULT_COUNT(fc));
  // Expected limit: reference times percentage
  function [31:0] exp_scaled(input [15:0] t, input [7:0] p);
    exp_scaled = t * p / 100;
  endfunction
  // Compare and count
  task check(input [31:0] seen, input [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bounded wait for a state
  task wait_state(input [2:0] s);
    for (k = 0; k < 60 && STATE !== s; k = k + 1) @(posedge MCLK) #1;
    if (STATE !== s) begin
      bad_count = bad_count + 1;
      give_verdict;
    end
  endtask
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence
  initial begin
    i = $urandom(77440);
    saved = ($urandom & 32'h0fff_ffff) + 32'h1000;
    apos = saved + 32'd910;  // Just under 5 degrees away
    repeat (3) @(posedge MCLK);
    #1 RESET = 1'b0;
    check(spr, 32'h00010000);
    wait_state(`ST_INHIBIT);
    check(readj, 1'b1);
    check(pt, saved);
    apos = 32'h100;
    scanner_model_i.cyc(16'h0001, 8'h32, 8'h32, 32'h100);
    check(STATE, `ST_INHIBIT);
    scanner_model_i.cyc(16'h0000, 8'h32, 8'h32, 32'h100);
    wait_state(`ST_READY);
    $display("test inhibit exit done");
    check(readj, 1'b0);
    #1 apos = 32'h108;  // Inside tolerance
    repeat (2) @(posedge MCLK);
    #1 check(readj, 1'b0);
    apos = 32'h120;  // Pushed outside tolerance
    repeat (2) @(posedge MCLK);
    #1 check(readj, 1'b1);
    apos = 32'h100;
    repeat (2) @(posedge MCLK);
    #1 check(readj, 1'b0);
    $display("test position hold done");
    for (d = 0; d < 6; d = d + 1) begin
      n = (d == 0) ? 1 : $urandom % 1000 + 1;
      i = (d == 1) ? 256 : $urandom % 255 + 1;
      scanner_model_i.acy(`PNU_NUMERATOR, n);
      scanner_model_i.acy(`PNU_DENOMINATOR, i);
      scanner_model_i.acy(`PNU_DENOMINATOR, 0);
      repeat (3) @(posedge MCLK);
      check(spr, 256 * n / i);
    end
    $display("test resolution done");
    #1 nom = $urandom;
    n = $urandom % 100 + 1;
    d = $urandom % 65536;
    scanner_model_i.acy(`PNU_SPEED_REF, d);
    scanner_model_i.cyc(16'h000f, 8'h40, n, 32'h2000);
    repeat (3) @(posedge MCLK);
    check(tl, exp_scaled(nom, n));
    check(sl, exp_scaled(d, 8'h40));
    scanner_model_i.acy(`PNU_TORQUE_MAX, 32'h5);
    repeat (3) @(posedge MCLK);
    check(tl, exp_scaled(nom, n));
    #1 START = 1'b1;
    wait_state(`ST_RUN);
    #1 BLOCKED = 1'b1;
    @(posedge MCLK) #1 BLOCKED = 1'b0;
    START = 1'b0;
    check(abort, 1'b1);
    wait_state(`ST_FAULT);
    check(fc, 4'h1);
    @(posedge MCLK) #1 check(fe, `FAULT_CODE_BLOCK);
    check(abort, 1'b0);
    scanner_model_i.cyc(16'h0080, 8'h40, n, 32'h2000);
    check(STATE, `ST_FAULT);
    scanner_model_i.cyc(16'h0000, 8'h40, n, 32'h2000);
    wait_state(`ST_INHIBIT);
    $display("test blockage fault done");
    scanner_model_i.cyc(16'h0001, 8'h40, n, 32'h2000);
    scanner_model_i.cyc(16'h0000, 8'h40, n, 32'h2000);
    wait_state(`ST_READY);
    #1 START = 1'b1;
    wait_state(`ST_RUN);
    #1 scanner_model_i.alive_en = 1'b0;
    START = 1'b0;
    repeat (TO - 2) @(posedge MCLK);
    #1 check(tmo, 1'b0);
    for (k = 0; k < 8 && abort !== 1'b1; k = k + 1) @(posedge MCLK) #1;
    check(abort, 1'b1);
    check(STATE == `ST_RUN, 1'b0);
    check(tmo, 1'b1);
    START = 1'b1;
    wait_state(`ST_RUN);
    START = 1'b0;
    @(posedge MCLK) #1 check(abort, 1'b1);
    $display("test master timeout done");
    #1 RESET = 1'b1;
    apos = saved - 32'd911;  // Just over 5 degrees away
    repeat (2) @(posedge MCLK);
    #1 RESET = 1'b0;
    @(posedge MCLK) #1 check(readj, 1'b0);
    check(spr, 32'h00010000);
    $display("test readjust window done");
    give_verdict;
  end
endmodule
bind drive_supervisor drive_supervisor_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES))
  drive_supervisor_sva_i (.MCLK(MCLK), .RESET(RESET), .CYC_VALID(CYC_VALID),
  .CYC_STROBE(CYC_STROBE), .CYC_CONTROL(CYC_CONTROL), .CYC_TARGET(CYC_TARGET),
  .BLOCKED(BLOCKED), .COMM_ALIVE(COMM_ALIVE), .STATE(STATE), .RUN_ABORT(RUN_ABORT),
  .STEPS_PER_REV(STEPS_PER_REV), .CONTROL_WORD(CONTROL_WORD),
  .POS_TARGET(POS_TARGET), .COMM_TIMEOUT(COMM_TIMEOUT), .FAULT_COUNT(FAULT_COUNT));

// >>> sim/drive_supervisor_sva.sv
/*
  Checker for the drive supervisor, bound to its top module.
  Assumes MCLK, synchronous active high RESET and the state codes of the header.
*/
`timescale 1ns/1ps
`include "drive_supervisor_regs.vh"
module drive_supervisor_sva #(
  parameter [31:0] TIMEOUT_CYCLES = 32'd50
) (
  input wire        MCLK,
  input wire        RESET,
  input wire        CYC_VALID,
  input wire        CYC_STROBE,
  input wire [15:0] CYC_CONTROL,
  input wire [31:0] CYC_TARGET,
  input wire        BLOCKED,
  input wire        COMM_ALIVE,
  input wire [2:0]  STATE,
  input wire        RUN_ABORT,
  input wire [31:0] STEPS_PER_REV,
  input wire [15:0] CONTROL_WORD,
  input wire [31:0] POS_TARGET,
  input wire        COMM_TIMEOUT,
  input wire [3:0]  FAULT_COUNT
);
  reg [31:0] quiet_q;  // Cycles without master traffic
  // Count silence, saturating well past the timeout
  always @(posedge MCLK) begin
    if (RESET || COMM_ALIVE) quiet_q <= 32'h0;
    else if (quiet_q < TIMEOUT_CYCLES + 32'd8) quiet_q <= quiet_q + 32'h1;
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  // Blockage seen while running
  sequence blocked_run; STATE == `ST_RUN && BLOCKED; endsequence
  // Fault entered with abort pulse
  sequence fault_entry; STATE == `ST_FAULT && RUN_ABORT; endsequence
  a_block_to_fault: assert property (blocked_run |=> fault_entry)
    else $error("blockage in run did not give fault and abort");
  a_fault_logged: assert property (STATE == `ST_RUN && BLOCKED && FAULT_COUNT < 4'h8
    |=> FAULT_COUNT == $past(FAULT_COUNT) + 4'h1) else $error("fault not logged");
  a_ack_exit: assert property (STATE == `ST_FAULT && $fell(CONTROL_WORD[7])
    |-> ##[1:2] STATE == `ST_INHIBIT) else $error("acknowledge did not leave fault");
  a_inhibit_exit: assert property (STATE == `ST_INHIBIT && $fell(CONTROL_WORD[0])
    |-> ##[1:2] STATE == `ST_READY) else $error("switch on edge did not leave inhibit");
  a_steps_reset: assert property (disable iff (1'b0) RESET |=>
    STEPS_PER_REV == 32'h00010000) else $error("resolution not restored by reset");
  a_cyclic_wins: assert property (CYC_VALID && CYC_STROBE |=>
    CONTROL_WORD == $past(CYC_CONTROL) && POS_TARGET == $past(CYC_TARGET))
    else $error("cyclic data not taken");
  a_timeout_seen: assert property (quiet_q > TIMEOUT_CYCLES + 32'd2 |-> COMM_TIMEOUT)
    else $error("master silence not flagged");
  a_timeout_abort: assert property (COMM_TIMEOUT && STATE == `ST_RUN
    |-> ##[0:1] RUN_ABORT) else $error("timeout did not abort run");
  a_abort_cause: assert property (RUN_ABORT |-> $past(STATE) == `ST_RUN)
    else $error("abort outside a run");
endmodule

// >>> sim/scanner_model.sv
/*
  Scanner model: sends cyclic frames and acyclic parameter writes.
  Assumes the bench calls its tasks and sets alive_en.
*/
`timescale 1ns/1ps
module scanner_model (
  input  wire        MCLK,
  output reg         CYC_VALID,
  output reg         CYC_STROBE,
  output reg  [15:0] CYC_CONTROL,
  output reg  [7:0]  CYC_SPEED_PCT,
  output reg  [7:0]  CYC_TORQUE_PCT,
  output reg  [31:0] CYC_TARGET,
  output reg         ACY_WRITE,
  output reg  [8:0]  ACY_PNU,
  output reg  [31:0] ACY_VALUE,
  output reg         COMM_ALIVE
);
  reg alive_en = 1'b1;  // Traffic switch for timeout tests
  initial begin
    {CYC_VALID, CYC_STROBE, ACY_WRITE} = 3'h0;
    {CYC_CONTROL, CYC_SPEED_PCT, CYC_TORQUE_PCT, CYC_TARGET} = 64'h0;
    ACY_PNU = 9'h0;
    ACY_VALUE = 32'h0;
  end
  // Master traffic marker
  always @(posedge MCLK) COMM_ALIVE <= #1 alive_en;
  // One cyclic frame; nonzero limits before any run
  task cyc(input [15:0] cw, input [7:0] sp, input [7:0] tq, input [31:0] tg);
    @(posedge MCLK) #1;
    {CYC_VALID, CYC_STROBE, CYC_CONTROL} = {2'b11, cw};
    {CYC_SPEED_PCT, CYC_TORQUE_PCT, CYC_TARGET} = {sp, tq, tg};
    @(posedge MCLK) #1 CYC_STROBE = 1'b0;
  endtask
  // One acyclic write, e.g. maxima before a start
  task acy(input [8:0] pnu, input [31:0] v);
    @(posedge MCLK) #1 {ACY_WRITE, ACY_PNU, ACY_VALUE} = {1'b1, pnu, v};
    @(posedge MCLK) #1 ACY_WRITE = 1'b0;
  endtask
endmodule
